// [rtl/piet_pkg.sv]
`default_nettype none
package piet_pkg;
    // ----------------------------------------------------------------
    // per-source control register layout
    // ----------------------------------------------------------------
    localparam int ICR_LV_LSB = 0;
    localparam int ICR_LV_W = 4;
    localparam int ICR_CH_LSB = 4;
    localparam int ICR_CH_W = 3;
    localparam int ICR_ET_BIT = 7;
    localparam int ICR_EN_BIT = 8;
    localparam int ICR_REQ_BIT = 9;
    localparam int ICR_W = 10;
    localparam logic [ICR_W-1:0] ICR_RST = 10'h000;

    // ----------------------------------------------------------------
    // transfer channel control layout
    // ----------------------------------------------------------------
    localparam int CC_CNT_LSB = 0;
    localparam int CC_CNT_W = 8;
    localparam int CC_WORD_BIT = 8;
    localparam int CC_CONT_BIT = 9;
    localparam int CC_INCDST_BIT = 10;
    localparam int CC_W = 11;
    localparam logic [CC_W-1:0] CC_RST = 11'h000;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_ICR_BASE = 12'h000;
    localparam logic [11:0] OFS_CH_BASE = 12'h100;
    localparam logic [11:0] OFS_STAT = 12'h200;
    localparam logic [11:0] OFS_MASK = 12'h204;
    localparam logic [11:0] OFS_CORE = 12'h208;
    localparam logic [11:0] OFS_EDGE = 12'h20c;
    localparam logic [1:0] CH_FLD_CTRL = 2'h0;
    localparam logic [1:0] CH_FLD_SRC = 2'h1;
    localparam logic [1:0] CH_FLD_DST = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // trap numbers and response timing
    // ----------------------------------------------------------------
    localparam logic [6:0] TRAP_CC0 = 7'h10;
    localparam logic [6:0] TRAP_CC16 = 7'h30;
    localparam logic [6:0] TRAP_CC29 = 7'h44;
    localparam int CLK_PERIOD_NS = 20;
    localparam int LAT_MIN_NS = 157;
    localparam int LAT_MAX_NS = 375;
    localparam int LAT_MIN_CYC = (LAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LAT_MAX_CYC = LAT_MAX_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        PIET_IDLE = 2'b00,
        PIET_WAIT = 2'b01,
        PIET_OFFER = 2'b11,
        PIET_XFER = 2'b10
    } piet_state_e;

    typedef enum logic [2:0]
    {
        PIET_R_NONE, PIET_R_ICR, PIET_R_CH, PIET_R_STAT, PIET_R_MASK, PIET_R_CORE, PIET_R_EDGE
    } piet_reg_e;

    // trap number of a capture/compare source; vector location is four times it
    function automatic logic [6:0] piet_trap_of(input logic [5:0] idx);
        if (idx < 6'd16)
        begin
            return TRAP_CC0 + {1'b0, idx};
        end
        else if (idx < 6'd29)
        begin
            return TRAP_CC16 + {1'b0, idx - 6'd16};
        end
        return TRAP_CC29 + {1'b0, idx - 6'd29};
    endfunction : piet_trap_of
endpackage : piet_pkg
`default_nettype wire

// [rtl/piet_ctrl.sv]
`default_nettype none
module piet_ctrl
    import piet_pkg::*;
#(
    parameter int NUM_SRC = 18,
    parameter int NUM_CH = 8,
    parameter int NUM_EXT = 4,
    parameter int ADDR_W = 24
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // request sources
    input wire logic [NUM_SRC-1:0] srcReq,
    input wire logic [NUM_EXT-1:0] extPin,
    // core: standard interrupt
    output logic irqValid,
    output logic [ADDR_W-1:0] irqVector,
    output logic [6:0] irqTrapNum,
    output logic [3:0] irqLevel,
    input wire logic irqAck,
    input wire logic retiPulse,
    output logic [3:0] cpuLevel,
    input wire logic hwTrapActive,
    // core: software trap
    input wire logic swTrapValid,
    input wire logic [6:0] swTrapNum,
    output logic swTrapDone,
    output logic swTrapKnown,
    output logic [ADDR_W-1:0] swTrapVector,
    // core: stolen transfer cycle
    output logic xferValid,
    output logic [ADDR_W-1:0] xferSrcAddr,
    output logic [ADDR_W-1:0] xferDstAddr,
    output logic xferWord,
    input wire logic xferReady,
    // summary interrupt
    output logic irq
);
    localparam int SEL_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;
    localparam int ST_W = NUM_CH + 1;
    localparam logic [7:0] LAT_MIN_C = 8'(LAT_MIN_CYC);
    localparam logic [7:0] LAT_MAX_C = 8'(LAT_MAX_CYC);

    typedef struct packed {
        logic [NUM_SRC-1:0][ICR_W-1:0] icr;
        logic [NUM_CH-1:0][CC_W-1:0] chCtrl;
        logic [NUM_CH-1:0][ADDR_W-1:0] chSrc;
        logic [NUM_CH-1:0][ADDR_W-1:0] chDst;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] mask;
        logic [15:0] activeLv;
        piet_state_e fsm;
        logic [SEL_W-1:0] winner;
        logic [7:0] latCnt;
        logic [2*NUM_EXT-1:0] edgeSel;
        logic [NUM_EXT-1:0] sync1;
        logic [NUM_EXT-1:0] sync2;
        logic [NUM_EXT-1:0] sync3;
        logic awHeld;
        logic wHeld;
        logic [11:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        logic [ADDR_W-1:0] xSrc;
        logic [ADDR_W-1:0] xDst;
        logic xWord;
        logic swHit;
        logic swKnown;
        logic [ADDR_W-1:0] swVec;
        logic [ADDR_W-1:0] irqVec;
        logic [6:0] irqTrap;
        logic [3:0] irqLv;
    } piet_state_s;

    piet_state_s s_reg;
    piet_state_s s_next;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // index of the highest active nesting level, zero when none
    function automatic logic [3:0] topLevel(input logic [15:0] lv);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 1; i < 16; i++)
        begin
            if (lv[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : topLevel

    // byte-lane merge of a write onto the old register value
    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (st[b])
            begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction : mergeStrb

    // address decode shared by reads and writes; idx is source or channel
    function automatic piet_reg_e decodeKind(input logic [11:0] a);
        if (a[1:0] != 2'b00)
        begin
            return PIET_R_NONE;
        end
        if (a < OFS_ICR_BASE + 12'(4 * NUM_SRC))
        begin
            return PIET_R_ICR;
        end
        if (a >= OFS_CH_BASE && a < OFS_CH_BASE + 12'(16 * NUM_CH) && a[3:2] != 2'b11)
        begin
            return PIET_R_CH;
        end
        case (a)
            OFS_STAT: return PIET_R_STAT;
            OFS_MASK: return PIET_R_MASK;
            OFS_CORE: return PIET_R_CORE;
            OFS_EDGE: return PIET_R_EDGE;
            default: return PIET_R_NONE;
        endcase
    endfunction : decodeKind

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic found;
        logic [3:0] bestLv;
        logic [SEL_W-1:0] bestIdx;
        logic [3:0] curLv;
        logic [ICR_W-1:0] w;
        logic [2:0] ch;
        logic [CC_W-1:0] cc;
        logic useXfer;
        logic [NUM_EXT-1:0] rise;
        logic [NUM_EXT-1:0] fall;
        logic [NUM_SRC-1:0] hwSet;
        logic [ST_W-1:0] statSet;
        logic [11:0] a;
        logic [5:0] ri;
        logic [31:0] rd;
        found = 1'b0;
        bestLv = 4'h0;
        bestIdx = '0;
        curLv = topLevel(s_reg.activeLv);
        w = '0;
        ch = 3'h0;
        cc = '0;
        useXfer = 1'b0;
        rise = s_reg.sync2 & ~s_reg.sync3;
        fall = ~s_reg.sync2 & s_reg.sync3;
        hwSet = srcReq;
        statSet = '0;
        a = 12'h000;
        ri = 6'h00;
        rd = 32'h0000_0000;
        s_next = s_reg;

        // external pins: two-stage sync, third stage for edge detect
        s_next.sync1 = extPin;
        s_next.sync2 = s_reg.sync1;
        s_next.sync3 = s_reg.sync2;
        for (int e = 0; e < NUM_EXT && e < NUM_SRC; e++)
        begin
            if ((s_reg.edgeSel[2*e] && rise[e]) || (s_reg.edgeSel[2*e+1] && fall[e]))
            begin
                hwSet[e] = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // register bus: write address and data taken in either order
        // ------------------------------------------------------------
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_next.awHeld = 1'b1;
            s_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_next.wHeld = 1'b1;
            s_next.wData = s_axi_wdata;
            s_next.wStrb = s_axi_wstrb;
        end
        if (s_reg.bValid && s_axi_bready)
        begin
            s_next.bValid = 1'b0;
        end
        if (s_reg.awHeld && s_reg.wHeld && !s_reg.bValid)
        begin
            a = s_reg.awAddr;
            s_next.awHeld = 1'b0;
            s_next.wHeld = 1'b0;
            s_next.bValid = 1'b1;
            s_next.bResp = RESP_OKAY;
            case (decodeKind(a))
                PIET_R_ICR:
                begin
                    ri = a[7:2];
                    s_next.icr[ri] = ICR_W'(mergeStrb(32'(s_reg.icr[ri]), s_reg.wData,
                                                       s_reg.wStrb));
                end
                PIET_R_CH:
                begin
                    ri = {3'h0, a[6:4]};
                    case (a[3:2])
                        CH_FLD_CTRL: s_next.chCtrl[ri] = CC_W'(mergeStrb(32'(s_reg.chCtrl[ri]),
                                                          s_reg.wData, s_reg.wStrb));
                        CH_FLD_SRC: s_next.chSrc[ri] = ADDR_W'(mergeStrb(32'(s_reg.chSrc[ri]),
                                                         s_reg.wData, s_reg.wStrb));
                        default: s_next.chDst[ri] = ADDR_W'(mergeStrb(32'(s_reg.chDst[ri]),
                                                        s_reg.wData, s_reg.wStrb));
                    endcase
                end
                PIET_R_MASK: s_next.mask = ST_W'(mergeStrb(32'(s_reg.mask), s_reg.wData,
                                                          s_reg.wStrb));
                PIET_R_EDGE: s_next.edgeSel = (2*NUM_EXT)'(mergeStrb(32'(s_reg.edgeSel),
                                                                    s_reg.wData, s_reg.wStrb));
                PIET_R_STAT, PIET_R_CORE: s_next.bResp = RESP_OKAY; // read-only, write ignored
                default: s_next.bResp = RESP_SLVERR;
            endcase
        end

        // ------------------------------------------------------------
        // register bus: read, status cleared by its own read
        // ------------------------------------------------------------
        if (s_reg.rValid && s_axi_rready)
        begin
            s_next.rValid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            a = s_axi_araddr;
            s_next.rValid = 1'b1;
            s_next.rResp = RESP_OKAY;
            case (decodeKind(a))
                PIET_R_ICR: rd = 32'(s_reg.icr[a[7:2]]);
                PIET_R_CH:
                begin
                    case (a[3:2])
                        CH_FLD_CTRL: rd = 32'(s_reg.chCtrl[a[6:4]]);
                        CH_FLD_SRC: rd = 32'(s_reg.chSrc[a[6:4]]);
                        default: rd = 32'(s_reg.chDst[a[6:4]]);
                    endcase
                end
                PIET_R_STAT:
                begin
                    rd = 32'(s_reg.stat);
                    s_next.stat = '0;
                end
                PIET_R_MASK: rd = 32'(s_reg.mask);
                PIET_R_CORE: rd = {8'h00, s_reg.fsm, 1'b0, hwTrapActive, curLv, s_reg.activeLv};
                PIET_R_EDGE: rd = 32'(s_reg.edgeSel);
                default: s_next.rResp = RESP_SLVERR;
            endcase
            s_next.rData = rd;
        end

        // ------------------------------------------------------------
        // nesting levels: return from service drops the top level
        // ------------------------------------------------------------
        if (retiPulse)
        begin
            s_next.activeLv[curLv] = 1'b0;
        end

        // software trap: same vector as the source with that number
        s_next.swHit = swTrapValid;
        if (swTrapValid)
        begin
            s_next.swVec = ADDR_W'({swTrapNum, 2'b00});
            s_next.swKnown = 1'b0;
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (piet_trap_of(6'(i)) == swTrapNum)
                begin
                    s_next.swKnown = 1'b1;
                end
            end
        end

        // ------------------------------------------------------------
        // arbitration: highest level wins, lower index on a tie
        // ------------------------------------------------------------
        for (int i = 0; i < NUM_SRC; i++)
        begin
            w = s_reg.icr[i];
            if (w[ICR_REQ_BIT] && w[ICR_EN_BIT] &&
                (!found || w[ICR_LV_LSB +: ICR_LV_W] > bestLv))
            begin
                found = 1'b1;
                bestLv = w[ICR_LV_LSB +: ICR_LV_W];
                bestIdx = SEL_W'(i);
            end
        end
        w = s_reg.icr[bestIdx];
        ch = w[ICR_CH_LSB +: ICR_CH_W];
        cc = s_reg.chCtrl[ch];
        // counter at zero outside continuous mode falls back to a vector
        useXfer = w[ICR_ET_BIT] && (32'(ch) < NUM_CH) &&
                  (cc[CC_CONT_BIT] || cc[CC_CNT_LSB +: CC_CNT_W] != '0);

        case (s_reg.fsm)
            PIET_IDLE:
            begin
                // strictly higher than the running level; traps block all
                if (found && bestLv > curLv && !hwTrapActive)
                begin
                    s_next.winner = bestIdx;
                    s_next.xSrc = s_reg.chSrc[ch];
                    s_next.xDst = s_reg.chDst[ch];
                    s_next.xWord = cc[CC_WORD_BIT];
                    s_next.irqTrap = piet_trap_of(6'(bestIdx));
                    s_next.irqVec = ADDR_W'({piet_trap_of(6'(bestIdx)), 2'b00});
                    s_next.irqLv = bestLv;
                    s_next.latCnt = 8'h01;
                    s_next.fsm = useXfer ? PIET_XFER : PIET_WAIT;
                end
            end
            PIET_WAIT:
            begin
                // hold back the offer so the response never beats the floor
                s_next.latCnt = s_reg.latCnt + 8'h01;
                if (hwTrapActive)
                begin
                    // a trap arriving mid-wait must not be followed by an offer
                    s_next.fsm = PIET_IDLE;
                end
                else if (s_reg.latCnt >= LAT_MIN_C - 8'h01)
                begin
                    s_next.fsm = PIET_OFFER;
                end
            end
            PIET_OFFER:
            begin
                if (s_reg.latCnt != 8'hff)
                begin
                    s_next.latCnt = s_reg.latCnt + 8'h01;
                end
                if (s_reg.latCnt == LAT_MAX_C)
                begin
                    statSet[NUM_CH] = 1'b1;
                end
                w = s_reg.icr[s_reg.winner];
                if (irqAck)
                begin
                    // core suspends the program and enters this level
                    s_next.icr[s_reg.winner][ICR_REQ_BIT] = 1'b0;
                    s_next.activeLv[s_reg.irqLv] = 1'b1;
                    s_next.fsm = PIET_IDLE;
                end
                else if (hwTrapActive || !w[ICR_REQ_BIT] || !w[ICR_EN_BIT])
                begin
                    s_next.fsm = PIET_IDLE;
                end
            end
            PIET_XFER:
            begin
                w = s_reg.icr[s_reg.winner];
                ch = w[ICR_CH_LSB +: ICR_CH_W];
                cc = s_reg.chCtrl[ch];
                if (xferReady)
                begin
                    s_next.icr[s_reg.winner][ICR_REQ_BIT] = 1'b0;
                    if (cc[CC_INCDST_BIT])
                    begin
                        s_next.chDst[ch] = s_reg.chDst[ch] +
                                           (cc[CC_WORD_BIT] ? ADDR_W'(2) : ADDR_W'(1));
                    end
                    else
                    begin
                        s_next.chSrc[ch] = s_reg.chSrc[ch] +
                                           (cc[CC_WORD_BIT] ? ADDR_W'(2) : ADDR_W'(1));
                    end
                    if (!cc[CC_CONT_BIT])
                    begin
                        s_next.chCtrl[ch][CC_CNT_LSB +: CC_CNT_W] =
                            cc[CC_CNT_LSB +: CC_CNT_W] - 8'h01;
                        if (cc[CC_CNT_LSB +: CC_CNT_W] == 8'h01)
                        begin
                            // leave the request up so it comes back as a vector
                            s_next.icr[s_reg.winner][ICR_REQ_BIT] = 1'b1;
                            statSet[ch] = 1'b1;
                        end
                    end
                    s_next.fsm = PIET_IDLE;
                end
                else if (hwTrapActive)
                begin
                    s_next.fsm = PIET_IDLE;
                end
            end
            default: s_next.fsm = PIET_IDLE;
        endcase

        // hardware sets win over software and service clears
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (hwSet[i])
            begin
                s_next.icr[i][ICR_REQ_BIT] = 1'b1;
            end
        end
        s_next.stat = s_next.stat | statSet;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = !s_reg.awHeld && !s_reg.bValid;
    assign s_axi_wready = !s_reg.wHeld && !s_reg.bValid;
    assign s_axi_bvalid = s_reg.bValid;
    assign s_axi_bresp = s_reg.bResp;
    assign s_axi_arready = !s_reg.rValid;
    assign s_axi_rvalid = s_reg.rValid;
    assign s_axi_rdata = s_reg.rData;
    assign s_axi_rresp = s_reg.rResp;
    assign irqValid = (s_reg.fsm == PIET_OFFER);
    assign irqVector = s_reg.irqVec;
    assign irqTrapNum = s_reg.irqTrap;
    assign irqLevel = s_reg.irqLv;
    assign cpuLevel = topLevel(s_reg.activeLv);
    assign swTrapDone = s_reg.swHit;
    assign swTrapKnown = s_reg.swKnown;
    assign swTrapVector = s_reg.swVec;
    assign xferValid = (s_reg.fsm == PIET_XFER);
    assign xferSrcAddr = s_reg.xSrc;
    assign xferDstAddr = s_reg.xDst;
    assign xferWord = s_reg.xWord;
    // level interrupt while any unmasked sticky event stands
    assign irq = |(s_reg.stat & s_reg.mask);
endmodule : piet_ctrl
`default_nettype wire

// [sim/piet_props.sv]
`default_nettype none
module piet_props
(
    // watched ports
    input wire logic clk_sys, rst_n, irqValid, irqAck, hwTrapActive,
    input wire logic swTrapValid, swTrapDone, xferValid, xferReady,
    input wire logic [23:0] irqVector, swTrapVector, xferSrcAddr,
    input wire logic [6:0] irqTrapNum, swTrapNum
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ----
    // service paths
    // ----
    chk_vec_four: assert property (irqValid |-> irqVector == 24'(irqTrapNum) * 4)
        else $error("vector not four times trap");
    chk_sw_vector: assert property
        (swTrapValid |=> swTrapDone && swTrapVector == 24'($past(swTrapNum)) * 4)
        else $error("bad software trap answer");
    chk_hw_block: assert property (hwTrapActive [*2] |-> !irqValid && !xferValid)
        else $error("service offered during hardware trap");
    chk_xfer_hold: assert property
        (xferValid && !xferReady && !hwTrapActive |=> xferValid && $stable(xferSrcAddr))
        else $error("transfer dropped or moved");
    chk_xfer_one: assert property (xferValid && xferReady |=> !xferValid)
        else $error("transfer took more than one cycle");
    chk_irq_hold: assert property (irqValid && !irqAck && !hwTrapActive |=> irqValid)
        else $error("offer withdrawn");
    chk_one_path: assert property (!(irqValid && xferValid))
        else $error("interrupt and transfer at once");
    // next offer may not come within seven cycles of an accepted one
    chk_next_gap: assert property (irqAck |=> !irqValid [*7])
        else $error("offer too early");
    cov_ack: cover property (irqValid && irqAck);
    cov_xfer: cover property (xferValid && xferReady);
    cov_trap: cover property (swTrapDone);
endmodule : piet_props
`default_nettype wire

// [sim/piet_core_model.sv]
`default_nettype none
module piet_core_model
(
    // core handshake
    input wire logic clk_sys, rst_n, irqValid, xferValid,
    input wire logic [3:0] dly,
    output logic irqAck = 1'h0,
    output logic xferReady = 1'h0
);
    logic [3:0] waitCnt = 4'h0;
    // answer after dly cycles, one pulse each, so prompt and slow cores both show
    always @(posedge clk_sys)
    begin
        waitCnt <= (irqValid || xferValid) && waitCnt != 4'hf ? waitCnt + 4'h1 : 4'h0;
        irqAck <= rst_n && irqValid && !irqAck && waitCnt >= dly;
        xferReady <= rst_n && xferValid && !xferReady && waitCnt >= dly;
    end
endmodule : piet_core_model
`default_nettype wire

// [sim/tb.sv]
`default_nettype none
module tb import piet_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, retiPulse = 0, hwTrapActive = 0;
    logic swTrapValid = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irqValid, irqAck, swTrapDone, swTrapKnown, xferValid, xferWord;
    logic xferReady, irq;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf, coreDly = 0, extPin = 0, irqLevel, cpuLevel;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [17:0] srcReq = 0;
    logic [6:0] irqTrapNum, swTrapNum = 0;
    logic [23:0] irqVector, swTrapVector, xferSrcAddr, xferDstAddr;
    int err_total = 0, cmp_count = 0, cyc = 0;
    typedef struct packed {logic [11:0] ofs; logic [31:0] icr; logic [23:0] vec;} piet_row_s;
    // rising levels, so each row preempts the one before
    piet_row_s rows [4] = '{'{12'h0, 32'h301, 24'h40}, '{12'h3c, 32'h302, 24'h7c},
        '{12'h40, 32'h304, 24'hc0}, '{12'h44, 32'h30f, 24'hc4}};
    piet_ctrl i_dut (.*);
    piet_core_model i_core (.*, .dly(coreDly));
    always #10 clk_sys = ~clk_sys;
    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rdt(input logic [11:0] a);
        @(posedge clk_sys);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1);
        {rd, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    endtask : rdt
    // wait for an offer, check it, let the core model accept it
    task automatic serve(input logic [23:0] vec, input logic [3:0] lvl);
        while (irqValid !== 1'h1) @(posedge clk_sys);
        chk({irqVector, irqLevel}, {vec, lvl});
        while (irqValid === 1'h1) @(posedge clk_sys);
        chk(cpuLevel, lvl);
    endtask : serve
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge clk_sys) retiPulse <= 1'h1;
            @(posedge clk_sys) retiPulse <= 1'h0;
        end
    endtask : pulse
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // hang guard, the whole run needs a few hundred cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            summarize();
        end
    end
    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'h1;
        chk({irq, irqValid, xferValid}, 3'h0);
        foreach (rows[i])
        begin
            wr(rows[i].ofs, rows[i].icr);
            serve(rows[i].vec, rows[i].icr[3:0]);
        end
        wr(12'h00c, 32'h30e);
        repeat (20) @(posedge clk_sys);
        chk(irqValid, 1'h0);
        // level now high enough, but the trap must still hold it back
        hwTrapActive <= 1'h1;
        pulse(1);
        repeat (20) @(posedge clk_sys);
        chk(irqValid, 1'h0);
        hwTrapActive <= 1'h0;
        serve(24'h4c, 4'he);
        pulse(4);
        rdt(OFS_ICR_BASE);
        chk(rd, 32'h101);
        coreDly <= 4'h5;
        wr(OFS_CH_BASE, 32'h102);
        wr(OFS_CH_BASE + 12'h4, 32'h1000);
        wr(OFS_CH_BASE + 12'h8, 32'h2000);
        wr(OFS_MASK, 32'h1);
        wr(12'h014, 32'h381);
        for (int k = 0; k < 2; k++)
        begin
            while (xferValid !== 1'h1) @(posedge clk_sys);
            chk({xferSrcAddr, xferDstAddr, xferWord}, {24'h1000 + 24'(2 * k), 25'h4001});
            while (xferValid === 1'h1) @(posedge clk_sys);
            @(posedge clk_sys) srcReq[5] <= 1'h1;
            @(posedge clk_sys) srcReq[5] <= 1'h0;
        end
        serve(24'h54, 4'h1);
        chk(irq, 1'h1);
        rdt(OFS_STAT);
        chk(rd, 32'h1);
        rdt(12'h10c);
        chk({irq, rsp}, {1'h0, RESP_SLVERR});
        wr(12'h10c, 32'h5);
        chk(rsp, RESP_SLVERR);
        // pin 1 on rising edges only; a slow core also trips the late flag
        coreDly <= 4'hf;
        wr(OFS_EDGE, 32'h4);
        wr(12'h004, 32'h103);
        extPin[1] <= 1'h1;
        serve(24'h44, 4'h3);
        extPin[1] <= 1'h0;
        repeat (16) @(posedge clk_sys);
        chk(irqValid, 1'h0);
        rdt(OFS_STAT);
        chk(rd, 32'h100);
        @(posedge clk_sys) {swTrapNum, swTrapValid} <= 8'h61;
        @(posedge clk_sys) swTrapValid <= 1'h0;
        @(posedge clk_sys);
        chk({swTrapDone, swTrapKnown, swTrapVector}, {2'h3, 24'hc0});
        summarize();
    end
endmodule : tb
bind piet_ctrl piet_props i_props (.*);
`default_nettype wire
